// >>> bench/seep_chk.sv
/* Link checker for the serial memory pair.
   Assumes it watches the one interface joining both ends, on pclk. */
`timescale 1ns/1ps
`include "seep_params.svh"
module seep_chk #(
   parameter int unsigned WRITE_CYCLES = `SEEP_WR_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic sda,
   input wire logic busy
);
   // ********
   // Bus monitor
   // ********
   logic        scl_q;
   logic        sda_q;
   logic        first_q;
   logic        bsy_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic [31:0] bcnt_q;
   wire         rise     = scl && !scl_q;
   wire         start_ev = scl && scl_q && sda_q && !sda;
   wire         ack_bit  = rise && bit_q == 4'h8;

   // Count bits from each start; busy length counted for the timed cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         first_q <= 1'b0;
         bsy_q <= 1'b0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         bcnt_q <= 32'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         bcnt_q <= busy ? bcnt_q + 32'h1 : 32'h0;
         bsy_q <= start_ev ? busy : (bsy_q | busy);
         if (start_ev) begin
            bit_q <= 4'h0;
            first_q <= 1'b1;
         end else if (ack_bit) begin
            bit_q <= 4'h0;
            first_q <= 1'b0;
         end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
         end
      end
   end

   // ********
   // Assertions
   // ********
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
      else $error("device data moved while clock high");
   dev_take_a: assert property ($fell(dev_sda_oe_n) |-> !scl)
      else $error("device began driving while clock high");
   dev_free_a: assert property ($rose(dev_sda_oe_n) |-> !scl)
      else $error("device released while clock high");
   dev_low_a: assert property (ack_bit && !dev_sda_oe_n |-> (!dev_sda_oe_n && !sda)[*4])
      else $error("acknowledge not held low through clock high");
   busy_mute_a: assert property (busy |-> dev_sda_oe_n)
      else $error("device drives line while busy");
   busy_len_a: assert property ($fell(busy) |-> bcnt_q == WRITE_CYCLES)
      else $error("write cycle length wrong");
   start_hold_a: assert property ($fell(host_sda_oe_n) && scl |-> scl[*4])
      else $error("clock fell too soon after start");
   stop_hold_a: assert property ($rose(host_sda_oe_n) && scl && $past(scl) |-> scl[*4])
      else $error("clock fell too soon after stop");
   ctrl_nack_a: assert property (ack_bit && first_q && sh_q[7:4] != 4'ha |-> sda)
      else $error("foreign control code acknowledged");
   ctrl_ack_a: assert property (ack_bit && first_q && sh_q[7:4] == 4'ha && !bsy_q |-> !sda)
      else $error("control byte not acknowledged");
   mute_ack_a: assert property (ack_bit && busy |-> sda)
      else $error("acknowledge given while busy");

   cover property (start_ev);
   cover property ($fell(busy));
   cover property (ack_bit && !first_q && sda);
endmodule

// >>> bench/tb.sv
/* Self-checking bench: controller and memory joined on one link.
   Assumes the controller register map of seep_params.svh. */
`timescale 1ns/1ps
`include "seep_params.svh"
module tb;
   // Short write cycle keeps ack polling quick
   localparam int unsigned WC = 600;
   localparam int LIMIT = 60000;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        wp = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic [31:0] rd_w;
   logic        err_w;
   logic [7:0]  mem_m [0:2047];
   logic [10:0] ptr_m;
   logic [10:0] b;
   logic [3:0]  c;
   int          failures = 0;
   int          checked = 0;
   int          cyc = 0;
   int          seed = 32'he19e72d9;

   seep_if link ();
   seep_host u_seep_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   seep_dev #(.WRITE_CYCLES(WC)) u_seep_dev (.pclk(pclk), .presetn(presetn),
      .link(link.dev), .wp(wp), .busy(busy));
   seep_chk #(.WRITE_CYCLES(WC)) u_seep_chk (.pclk(pclk), .presetn(presetn), .scl(link.scl),
      .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda),
      .busy(busy));

   // ********
   // Clock, timeout, verdict
   // ********
   initial begin
      forever #10 pclk = ~pclk;
   end

   // A hang counts as a mismatch
   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_flag(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // ********
   // Bus tasks
   // ********
   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Ends once pready is seen high; without pready only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd_w = prdata;
      err_w = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Flags: 1 start, 2 stop, 4 read, 8 withhold ack; waits for the byte to finish
   task automatic cmd(input logic [3:0] fl, input logic [7:0] tx);
      apb(1'b1, `SEEP_CMD_OFS, {16'h0000, tx, 4'h0, fl});
      do begin
         apb(1'b0, `SEEP_STAT_OFS, 32'h0);
      end while (rd_w[`SEEP_STAT_BUSY] !== 1'b0);
   endtask

   task automatic poll(input logic exp_busy);
      int n;
      n = 0;
      cmd(4'h3, {4'ha, ptr_m[10:8], 1'b0});
      chk_flag("first poll ack", !exp_busy, rd_w[`SEEP_STAT_ACK]);
      while (rd_w[`SEEP_STAT_ACK] !== 1'b1 && n < 20) begin
         cmd(4'h3, {4'ha, ptr_m[10:8], 1'b0});
         n++;
      end
      chk_flag("poll ack", 1'b1, rd_w[`SEEP_STAT_ACK]);
   endtask

   // Expected page address: low four bits wrap, upper seven stay
   function automatic logic [10:0] page_addr(input logic [10:0] a, input int i);
      return {a[10:4], 4'(a[3:0] + i)};
   endfunction

   // Random data; only the low four pointer bits advance
   task automatic wr_page(input logic [10:0] a, input int n);
      logic [7:0] d;
      cmd(4'h1, {4'ha, a[10:8], 1'b0});
      chk_flag("ctrl ack", 1'b1, rd_w[`SEEP_STAT_ACK]);
      cmd(4'h0, a[7:0]);
      chk_flag("addr ack", 1'b1, rd_w[`SEEP_STAT_ACK]);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         cmd((i == n - 1) ? 4'h2 : 4'h0, d);
         chk_flag("data ack", 1'b1, rd_w[`SEEP_STAT_ACK]);
         if (!wp) mem_m[page_addr(a, i)] = d;
      end
      ptr_m = page_addr(a, n);
      poll(!wp);
   endtask

   // Random read when rnd is set, else from the current pointer
   task automatic rd_seq(input logic rnd, input logic [10:0] a, input int n);
      if (rnd) begin
         cmd(4'h1, {4'ha, a[10:8], 1'b0});
         cmd(4'h0, a[7:0]);
         ptr_m = a;
      end
      cmd(4'h1, {4'ha, ptr_m[10:8], 1'b1});
      chk_flag("read ctrl ack", 1'b1, rd_w[`SEEP_STAT_ACK]);
      for (int i = 0; i < n; i++) begin
         cmd((i == n - 1) ? 4'he : 4'h4, 8'h00);
         chk_word("read data", {24'h0, mem_m[ptr_m]}, {24'h0, rd_w[15:8]});
         ptr_m = ptr_m + 11'h001;
      end
   endtask

   // ********
   // Scenarios
   // ********
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      ptr_m = 11'h000;
      apb(1'b0, `SEEP_DIV_OFS, 32'h0);
      chk_word("div reset", {16'h0000, `SEEP_DIV_RST}, rd_w);
      apb(1'b1, `SEEP_DIV_OFS, 32'h00000004);
      apb(1'b0, 12'h00c, 32'h0);
      chk_flag("unmapped error", 1'b1, err_w);
      chk_word("unmapped data", 32'h0, rd_w);
      // Foreign device codes, one a single bit away
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 4'hb : 4'($random(seed));
         if (c == 4'ha) c = 4'h2;
         cmd(4'h3, {c, 4'($random(seed))});
         chk_flag("foreign code ack", 1'b0, rd_w[`SEEP_STAT_ACK]);
      end
      // Twenty bytes into one page: wraps, last sixteen stay
      b = {3'h3, 8'($random(seed)) & 8'hf0};
      wr_page(b | 11'h005, 20);
      rd_seq(1'b1, b, 16);
      wr_page(11'h000, 3);
      wr_page(11'h7ff, 1);
      rd_seq(1'b1, 11'h7ff, 3);
      rd_seq(1'b0, 11'h000, 1);
      // Protected writes are acked but change nothing
      wp <= 1'b1;
      wr_page(b, 4);
      rd_seq(1'b1, b, 4);
      wp <= 1'b0;
      tally_and_finish();
   end
endmodule

// >>> core/seep_dev.sv
/*
 * Serial memory slave: two-wire protocol front end, page buffer,
 * timed write cycle and the memory array.
 * Assumes scl, sda and wp are asynchronous pins; one controller drives
 * scl with high and low phases of at least four pclk cycles.
 */
// The register addresses and the APB interface to the registers were decided locally.
// Behaviour
// - Data changes only while clock low
// - Excess write bytes keep only last sixteen
// - Receiver acknowledges each byte on ninth clock
// - No acknowledge while programming cycle runs
// - Acknowledge holds data low whole high phase
// - Master nack ends read, line released
// - Control byte: code, block bits, direction
// - Acknowledge control byte only for code 1010
// - Block bits form top address bits
// - Byte write: control, address, data, stop
// - Page buffer commits only after stop
// - Write pointer increments low four bits only
// - Controller avoids page writes crossing boundaries
// - Polling gets ack once write finished
// - Write-protect pin blocks programming, not reads
// - Current-address read sends next address byte
// - Repeated start ends write without programming
// - Master ack advances pointer, next byte
// - Start is data falling while clock high
// - Stop is data rising while clock high
`timescale 1ns/1ps
`include "seep_params.svh"
module seep_dev #(
   parameter int unsigned WRITE_CYCLES = `SEEP_WR_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   seep_if.dev       link,
   input  wire logic wp,
   output logic      busy
);
   import seep_pkg::*;

   localparam int CW = $clog2(WRITE_CYCLES + 1);
   localparam int PB = `SEEP_PAGE_BYTES;
   localparam int AW = `SEEP_ADDR_W;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                    scl;
      logic                    sda;
      seep_dev_state_type      st;
      logic [3:0]              bits;
      seep_byte_type           sh;
      logic [1:0]              idx;
      logic                    rd;
      logic [AW-1:0]           addr;
      logic [AW-5:0]           page;
      logic [PB-1:0][7:0]      pbuf;
      logic [PB-1:0]           mask;
      logic                    drive;
      logic                    commit;
      logic                    busy;
      logic [CW-1:0]           wcnt;
   } seep_dev_type;

   seep_dev_type  s_q;
   seep_dev_type  s_d;
   seep_byte_type mem [0:`SEEP_MEM_BYTES-1];
   logic [2:0]    pins;
   logic          scl;
   logic          sda;
   logic          wp_s;
   logic          rise;
   logic          fall;
   logic          start;
   logic          stop;
   logic          ok;
   seep_byte_type rbyte;

   seep_sync #(.W(3)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({link.scl, link.sda, wp}),
      .q       (pins)
   );
   assign {scl, sda, wp_s} = pins;

   // ****************************************************************
   // Bus conditions
   // ****************************************************************
   assign rise  = scl & ~s_q.scl;
   assign fall  = ~scl & s_q.scl;
   assign start = scl & s_q.scl & s_q.sda & ~sda;
   assign stop  = scl & s_q.scl & ~s_q.sda & sda;
   assign rbyte = mem[s_q.addr];

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      s_d        = s_q;
      s_d.scl    = scl;
      s_d.sda    = sda;
      s_d.commit = 1'b0;
      ok         = 1'b0;
      // Self-timed write cycle
      if (s_q.busy) begin
         if (s_q.wcnt == CW'(WRITE_CYCLES - 1)) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.wcnt = s_q.wcnt + 1'b1;
         end
      end
      if (start) begin
         // Repeated start drops any pending page data
         s_d.st    = D_RX;
         s_d.bits  = 4'h0;
         s_d.idx   = 2'd0;
         s_d.mask  = '0;
         s_d.drive = 1'b0;
      end else if (stop) begin
         // Programming is launched only by a stop after data bytes
         if (s_q.st != D_IDLE && s_q.idx == 2'd2 && !s_q.rd && s_q.mask != '0
             && !wp_s) begin
            s_d.commit = 1'b1;
            s_d.busy   = 1'b1;
            s_d.wcnt   = '0;
         end
         s_d.st    = D_IDLE;
         s_d.drive = 1'b0;
      end else if (rise) begin
         // Sample on the rising edge, line is stable while high
         unique case (s_q.st)
            D_RX: begin
               s_d.sh   = {s_q.sh[6:0], sda};
               s_d.bits = s_q.bits + 4'h1;
            end
            D_TX: begin
               s_d.bits = s_q.bits + 4'h1;
            end
            D_TXACK: begin
               if (sda) begin
                  s_d.st = D_IDLE;
               end
            end
            D_IDLE, D_ACK: begin
            end
         endcase
      end else if (fall) begin
         // Drive changes only after the falling edge
         unique case (s_q.st)
            D_RX: begin
               if (s_q.bits == 4'h8) begin
                  unique case (s_q.idx)
                     2'd0: begin
                        ok = (s_q.sh[7:4] == `SEEP_CTRL_CODE);
                        if (ok && !s_q.busy) begin
                           s_d.addr[AW-1:8] = s_q.sh[3:1];
                           s_d.rd           = s_q.sh[0];
                           s_d.idx          = 2'd1;
                        end
                     end
                     2'd1: begin
                        ok           = 1'b1;
                        s_d.addr[7:0] = s_q.sh;
                        s_d.idx      = 2'd2;
                     end
                     default: begin
                        // Oldest entry at this slot is replaced
                        ok                        = 1'b1;
                        s_d.pbuf[s_q.addr[3:0]]   = s_q.sh;
                        s_d.mask[s_q.addr[3:0]]   = 1'b1;
                        s_d.page                  = s_q.addr[AW-1:4];
                        s_d.addr[3:0]             = s_q.addr[3:0] + 4'h1;
                     end
                  endcase
                  if (ok && !s_q.busy) begin
                     s_d.drive = 1'b1;
                     s_d.st    = D_ACK;
                  end else begin
                     s_d.st = D_IDLE;
                  end
               end
            end
            D_ACK, D_TXACK: begin
               // End of acknowledge: release, then next byte
               s_d.drive = 1'b0;
               s_d.bits  = 4'h0;
               if (s_q.rd) begin
                  s_d.sh    = rbyte;
                  s_d.drive = ~rbyte[7];
                  s_d.st    = D_TX;
               end else begin
                  s_d.st = D_RX;
               end
            end
            D_TX: begin
               if (s_q.bits == 4'h8) begin
                  // Pointer moves per byte sent, so a later read gets n+1
                  s_d.drive = 1'b0;
                  s_d.addr  = s_q.addr + 1'b1;
                  s_d.st    = D_TXACK;
               end else begin
                  s_d.sh    = {s_q.sh[6:0], 1'b0};
                  s_d.drive = ~s_q.sh[6];
               end
            end
            D_IDLE: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{scl: 1'b1, sda: 1'b1, st: D_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Array write of the buffered page; bytes never received keep old data
   always_ff @(posedge pclk) begin
      if (s_q.commit) begin
         for (int i = 0; i < PB; i++) begin
            if (s_q.mask[i]) begin
               mem[{s_q.page, 4'(i)}] <= s_q.pbuf[i];
            end
         end
      end
   end

   assign link.dev_sda_o    = 1'b0;
   assign link.dev_sda_oe_n = ~s_q.drive;
   assign busy              = s_q.busy;
endmodule

// >>> core/seep_host.sv
/*
 * Two-wire bus controller with an APB register port.
 * Assumes software builds control bytes and sequences; scl is made
 * here from pclk by a quarter-bit divider.
 */
`timescale 1ns/1ps
`include "seep_params.svh"
module seep_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   seep_if.host             link
);
   import seep_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      seep_host_state_type st;
      logic [1:0]          ph;
      logic [3:0]          bitn;
      seep_byte_type       sh;
      logic                stop;
      logic                rd;
      logic                nack;
      logic                ackd;
      logic                busy;
      logic                scl;
      logic                sda_low;
      logic [15:0]         div;
      logic [15:0]         cnt;
      logic [31:0]         rdat;
   } seep_host_type;

   seep_host_type s_q;
   seep_host_type s_d;
   logic          sda;
   logic          tick;
   logic          wr;
   logic [31:0]   rmux;

   seep_sync #(.W(1)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (link.sda),
      .q       (sda)
   );

   assign tick    = (s_q.cnt == 16'h0000);
   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;   // Zero-wait slave
   assign pslverr = psel & penable & (paddr != `SEEP_CMD_OFS) &
                    (paddr != `SEEP_STAT_OFS) & (paddr != `SEEP_DIV_OFS);

   // ****************************************************************
   // Register reads
   // ****************************************************************
   always_comb begin
      rmux = 32'h0000_0000;
      if (paddr == `SEEP_STAT_OFS) begin
         rmux[`SEEP_STAT_BUSY]                        = s_q.busy;
         rmux[`SEEP_STAT_ACK]                         = s_q.ackd;
         rmux[`SEEP_STAT_RXD_LSB+7:`SEEP_STAT_RXD_LSB] = s_q.sh;
      end else if (paddr == `SEEP_DIV_OFS) begin
         rmux[15:0] = s_q.div;
      end
   end

   // ****************************************************************
   // Command engine, one phase per quarter bit
   // ****************************************************************
   always_comb begin
      s_d     = s_q;
      s_d.cnt = tick ? s_q.div : s_q.cnt - 16'h0001;
      // Read word latched in the setup cycle, so prdata comes from a flop
      if (psel && !penable) begin
         s_d.rdat = rmux;
      end
      if (wr && paddr == `SEEP_DIV_OFS) begin
         s_d.div = pwdata[15:0];
      end
      // Commands while busy are dropped: one byte in flight only
      if (wr && paddr == `SEEP_CMD_OFS && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.stop = pwdata[`SEEP_CMD_STOP];
         s_d.rd   = pwdata[`SEEP_CMD_READ];
         s_d.nack = pwdata[`SEEP_CMD_NACK];
         s_d.sh   = pwdata[`SEEP_CMD_TXD_LSB+7:`SEEP_CMD_TXD_LSB];
         s_d.st   = pwdata[`SEEP_CMD_START] ? H_START : H_BIT;
         s_d.ph   = 2'd0;
         s_d.bitn = 4'h0;
         s_d.cnt  = s_q.div;
      end else if (s_q.st != H_IDLE && tick) begin
         s_d.ph = s_q.ph + 2'd1;
         unique case (s_q.st)
            H_START: begin
               // Release, clock high, then data falls: works repeated too
               unique case (s_q.ph)
                  2'd0: s_d.sda_low = 1'b0;
                  2'd1: s_d.scl     = 1'b1;
                  2'd2: s_d.sda_low = 1'b1;
                  2'd3: begin
                     s_d.scl  = 1'b0;
                     s_d.st   = H_BIT;
                     s_d.bitn = 4'h0;
                  end
               endcase
            end
            H_BIT: begin
               unique case (s_q.ph)
                  2'd0: begin
                     if (s_q.bitn != 4'h8) begin
                        s_d.sda_low = ~s_q.rd & ~s_q.sh[7];
                     end else begin
                        s_d.sda_low = s_q.rd & ~s_q.nack;
                     end
                  end
                  2'd1: s_d.scl = 1'b1;
                  2'd2: begin
                     if (s_q.bitn != 4'h8) begin
                        s_d.sh = {s_q.sh[6:0], sda};
                     end else if (!s_q.rd) begin
                        s_d.ackd = ~sda;
                     end
                  end
                  2'd3: begin
                     s_d.scl = 1'b0;
                     if (s_q.bitn == 4'h8) begin
                        // Free the line so the slave can send on
                        s_d.sda_low = 1'b0;
                        s_d.st      = s_q.stop ? H_STOP : H_IDLE;
                        s_d.busy    = s_q.stop;
                     end else begin
                        s_d.bitn = s_q.bitn + 4'h1;
                     end
                  end
               endcase
            end
            H_STOP: begin
               unique case (s_q.ph)
                  2'd0: s_d.sda_low = 1'b1;
                  2'd1: s_d.scl     = 1'b1;
                  2'd2: s_d.sda_low = 1'b0;
                  2'd3: begin
                     s_d.st   = H_IDLE;
                     s_d.busy = 1'b0;
                  end
               endcase
            end
            H_IDLE: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{st: H_IDLE, scl: 1'b1, div: `SEEP_DIV_RST, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata             = s_q.rdat;
   assign link.scl           = s_q.scl;
   assign link.host_sda_o    = 1'b0;
   assign link.host_sda_oe_n = ~s_q.sda_low;
endmodule

// >>> core/seep_if.sv
/*
 * Two-wire link between controller and memory slave.
 * Assumes an external pull-up on the data line: it resolves to the
 * AND of both open-drain drivers, enables active low.
 */
`timescale 1ns/1ps
interface seep_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;

   // Wired-AND with pull-up
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// >>> core/seep_params.svh
/*
 * Constants of the two-wire serial memory pair: protocol codes, memory
 * geometry, write-cycle timing and the controller's register map.
 * Assumes pclk runs at SEEP_CLK_MHZ.
 */
`ifndef SEEP_PARAMS_SVH
`define SEEP_PARAMS_SVH

// ****************************************************************
// Protocol and geometry
// ****************************************************************
`define SEEP_CTRL_CODE     4'ha
`define SEEP_PAGE_BYTES    16
`define SEEP_MEM_BYTES     2048
`define SEEP_ADDR_W        11

// ****************************************************************
// Timing
// ****************************************************************
`define SEEP_CLK_MHZ       50
`define SEEP_WR_TIME_US    10000
`define SEEP_WR_CYCLES     (`SEEP_WR_TIME_US * `SEEP_CLK_MHZ)

// ****************************************************************
// Controller registers (byte offsets, APB)
// ****************************************************************
`define SEEP_CMD_OFS       12'h000
`define SEEP_STAT_OFS      12'h004
`define SEEP_DIV_OFS       12'h008
`define SEEP_CMD_START     0
`define SEEP_CMD_STOP      1
`define SEEP_CMD_READ      2
`define SEEP_CMD_NACK      3
`define SEEP_CMD_TXD_LSB   8
`define SEEP_STAT_BUSY     0
`define SEEP_STAT_ACK      1
`define SEEP_STAT_RXD_LSB  8
`define SEEP_DIV_RST       16'h007d

`endif

// >>> core/seep_pkg.sv
/*
 * Types shared by the serial memory slave and its bus controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package seep_pkg;

   // ****************************************************************
   // State and byte types
   // ****************************************************************
   typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} seep_dev_state_type;
   typedef enum {H_IDLE, H_START, H_BIT, H_STOP}     seep_host_state_type;
   typedef logic [7:0]                                seep_byte_type;

endpackage

// >>> core/seep_sync.sv
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous to pclk; only the second stage is read.
 */
`timescale 1ns/1ps
module seep_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } seep_sync_type;

   seep_sync_type s_q;
   seep_sync_type s_d;

   // Shift the pin through both stages
   always_comb begin
      s_d      = s_q;
      s_d.meta = d;
      s_d.stab = s_q.meta;
   end

   // Pins idle high on this bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{meta: '1, stab: '1};
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stab;
endmodule
